// >>> hw/pfil_pkg.sv
package pfil_pkg;

	// Register byte offsets in configuration space.
	localparam logic [11:0] PFIL_STATUS_OFS = 12'hd1e;
	localparam logic [11:0] PFIL_MODE_OFS   = 12'hd20;
	localparam logic [11:0] PFIL_DATA0_OFS  = 12'hd24;
	localparam logic [11:0] PFIL_DATA1_OFS  = 12'hd28;
	localparam logic [11:0] PFIL_PROG_OFS   = 12'hd2c;
	localparam logic [11:0] PFIL_CREDIT_OFS = 12'hd48;

	// Status sits in the upper half of its dword.
	localparam int PFIL_STATUS_SHIFT = 16;

	// Status field positions.
	localparam int PFIL_ST_OK    = 10;
	localparam int PFIL_ST_CLK   = 8;
	localparam int PFIL_ST_DONE  = 7;
	localparam int PFIL_ST_USER  = 5;
	localparam int PFIL_ST_EN    = 4;
	localparam int PFIL_ST_ERR   = 3;
	localparam int PFIL_ST_READY = 2;

	// Mode, programming control and credit fields.
	localparam int PFIL_MODE_OFF   = 1;
	localparam int PFIL_MODE_RSVD  = 2;
	localparam int PFIL_PROG_XFER  = 1;
	localparam int PFIL_PROG_CFG   = 0;
	localparam int PFIL_CREDIT_LSB = 8;

	// Reset values.
	localparam logic        PFIL_BIT_RST    = 1'b0;
	localparam logic [7:0]  PFIL_CREDIT_RST = 8'h00;
	localparam logic [31:0] PFIL_DATA_RST   = 32'h00000000;
	// Board identifier beside the status half; arbitrary value.
	localparam logic [15:0] PFIL_BOARD_ID   = 16'h0000;

	// FIFO shape.
	localparam int PFIL_FIFO_W = 32;
	localparam int PFIL_FIFO_D = 4;

	// Status inputs from the configuration manager, as one bundle.
	typedef struct packed {
		logic ok;
		logic clk_sel;
		logic done;
		logic user;
		logic en;
		logic err;
		logic ready;
	} pfil_status_t;

endpackage : pfil_pkg

// >>> hw/pfil_regs.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Small first-word-fall-through FIFO; full and empty come from the fill count.
module pfil_fifo #(
	parameter int W = 32,
	parameter int D = 4
) (
	input  wire logic         clock_in,
	input  wire logic         rst_in,
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	input  wire logic [W-1:0] in_data_in,
	output logic              out_valid_out,
	input  wire logic         out_ready_in,
	output logic [W-1:0]      out_data_out
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;

	logic [W-1:0] mem_r [D];
	logic [AW-1:0] wptr_r;
	logic [AW-1:0] rptr_r;
	logic [AW:0]   count_r;
	logic          push;
	logic          pop;

	assign in_ready_out  = (count_r != (AW+1)'(D));
	assign out_valid_out = (count_r != '0);
	assign out_data_out  = mem_r[rptr_r];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	// Storage is not reset; only the pointers and fill count define what is valid.
	always_ff @(posedge clock_in)
	begin
		if (push)
			mem_r[wptr_r] <= in_data_in;
	end

	// Pointers wrap at the depth, which need not be a power of two.
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			wptr_r  <= '0;
			rptr_r  <= '0;
			count_r <= '0;
		end
		else
		begin
			if (push)
				wptr_r <= (wptr_r == AW'(D-1)) ? '0 : wptr_r + 1'b1;
			if (pop)
				rptr_r <= (rptr_r == AW'(D-1)) ? '0 : rptr_r + 1'b1;
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule : pfil_fifo

////////////////////////////////////////////////////////////////////////////////
module pfil_regs
	import pfil_pkg::*;
(
	input  wire logic               clock_in,
	input  wire logic               rst_in,
	input  wire logic               cfg_wr_in,
	input  wire logic               cfg_rd_in,
	input  wire logic [11:0]        cfg_addr_in,
	input  wire logic [3:0]         cfg_be_in,
	input  wire logic [31:0]        cfg_wdata_in,
	output logic [31:0]             cfg_rdata_out,
	output logic                    cfg_rvalid_out,
	input  wire logic               mem_wr_in,
	input  wire logic               mem_bar_hit_in,
	input  wire logic [31:0]        mem_wdata_in,
	input  wire pfil_status_t       status_in,
	input  wire logic               credit_free_in,
	output logic                    app_iface_off_out,
	output logic                    xfer_begin_out,
	output logic                    xfer_config_out,
	output logic [PFIL_FIFO_W-1:0]  img_data_out,
	output logic                    img_valid_out,
	input  wire logic               img_ready_in,
	output logic                    img_space_out
);

	// Compares the dword part of a byte address against a register offset.
	function automatic logic pfil_hit(input logic [11:0] addr, input logic [11:0] ofs);
		pfil_hit = (addr[11:2] == ofs[11:2]);
	endfunction : pfil_hit

	////////////////////////////////////////////////////////////////////////////
	pfil_status_t  sts_meta_r;
	pfil_status_t  sts_r;
	logic          off_r;
	logic          xfer_r;
	logic          cfgb_r;
	logic [7:0]    credit_r;
	logic [31:0]   data_r;
	logic [31:0]   rdata_r;
	logic          rvalid_r;
	logic [31:0]   rdata_nxt;
	logic          cfg_data_wr;
	logic          mem_data_wr;
	logic          fifo_in_valid;
	logic [31:0]   fifo_in_data;
	logic          fifo_in_ready;
	logic          fifo_out_valid;
	logic          fifo_out_ready;
	logic [31:0]   fifo_out_data;
	logic [31:0]   img_data_r;
	logic          img_valid_r;
	logic          space_r;
	logic [15:0]   sts_word;

	// The manager's status lives in its own clock domain, so each bit is
	// brought over by two flip-flops; only the second stage is ever read.
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sts_meta_r <= '0;
			sts_r      <= '0;
		end
		else
		begin
			sts_meta_r <= status_in;
			sts_r      <= sts_meta_r;
		end
	end

	// Status half-word; the two low reserved bits are held at zero.
	always_comb
	begin
		sts_word                = '0;
		sts_word[PFIL_ST_OK]    = sts_r.ok;
		sts_word[PFIL_ST_DONE]  = sts_r.done;
		sts_word[PFIL_ST_USER]  = sts_r.user;
		sts_word[PFIL_ST_EN]    = sts_r.en;
		sts_word[PFIL_ST_ERR]   = sts_r.err;
		sts_word[PFIL_ST_READY] = sts_r.ready;
		sts_word[PFIL_ST_CLK]   = sts_r.clk_sel;
	end

	////////////////////////////////////////////////////////////////////////////
	// Mode control: the detach bit is frozen unless the loader is enabled,
	// which keeps a stray write from cutting off a running application.
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			off_r <= PFIL_BIT_RST;
		else if (cfg_wr_in && pfil_hit(cfg_addr_in, PFIL_MODE_OFS) && cfg_be_in[0] && sts_r.en)
			off_r <= cfg_wdata_in[PFIL_MODE_OFF];
	end

	// Programming control bits, plain read-write flags.
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			xfer_r <= PFIL_BIT_RST;
			cfgb_r <= PFIL_BIT_RST;
		end
		else if (cfg_wr_in && pfil_hit(cfg_addr_in, PFIL_PROG_OFS) && cfg_be_in[0])
		begin
			xfer_r <= cfg_wdata_in[PFIL_PROG_XFER];
			cfgb_r <= cfg_wdata_in[PFIL_PROG_CFG];
		end
	end

	// Credit total counts each freed buffer; it wraps at 256 by design.
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			credit_r <= PFIL_CREDIT_RST;
		else if (credit_free_in)
			credit_r <= credit_r + 8'h01;
	end

	////////////////////////////////////////////////////////////////////////////
	// Image data path. Configuration writes always reach the data port; BAR
	// writes only while the loader is enabled. A configuration write wins a
	// same-cycle clash, since it cannot be retried by the bus.
	assign cfg_data_wr   = cfg_wr_in && (pfil_hit(cfg_addr_in, PFIL_DATA0_OFS)
	                       || pfil_hit(cfg_addr_in, PFIL_DATA1_OFS));
	assign mem_data_wr   = mem_wr_in && mem_bar_hit_in && sts_r.en;
	assign fifo_in_valid = cfg_data_wr || mem_data_wr;
	assign fifo_in_data  = cfg_data_wr ? cfg_wdata_in : mem_wdata_in;

	// Last accepted word reads back from the data register.
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			data_r <= PFIL_DATA_RST;
		else if (fifo_in_valid && fifo_in_ready)
			data_r <= fifo_in_data;
	end

	pfil_fifo #(
		.W (PFIL_FIFO_W),
		.D (PFIL_FIFO_D)
	) u_fifo (
		.clock_in      (clock_in),
		.rst_in        (rst_in),
		.in_valid_in   (fifo_in_valid),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (fifo_in_data),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (fifo_out_ready),
		.out_data_out  (fifo_out_data)
	);

	// Output stage keeps the stream driven straight from flops; the manager
	// stalls it with img_ready_in, which backs the FIFO up to the host.
	assign fifo_out_ready = !img_valid_r || img_ready_in;

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			img_valid_r <= 1'b0;
			img_data_r  <= PFIL_DATA_RST;
			space_r     <= 1'b0;
		end
		else
		begin
			space_r <= fifo_in_ready;
			if (fifo_out_ready)
			begin
				img_valid_r <= fifo_out_valid;
				if (fifo_out_valid)
					img_data_r <= fifo_out_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read decode; unmapped dwords and reserved bits return zero.
	always_comb
	begin
		rdata_nxt = '0;
		if (pfil_hit(cfg_addr_in, PFIL_STATUS_OFS))
			rdata_nxt = {sts_word, PFIL_BOARD_ID};
		else if (pfil_hit(cfg_addr_in, PFIL_MODE_OFS))
			rdata_nxt[PFIL_MODE_OFF] = off_r;
		else if (pfil_hit(cfg_addr_in, PFIL_DATA0_OFS) || pfil_hit(cfg_addr_in, PFIL_DATA1_OFS))
			rdata_nxt = data_r;
		else if (pfil_hit(cfg_addr_in, PFIL_PROG_OFS))
		begin
			rdata_nxt[PFIL_PROG_XFER] = xfer_r;
			rdata_nxt[PFIL_PROG_CFG]  = cfgb_r;
		end
		else if (pfil_hit(cfg_addr_in, PFIL_CREDIT_OFS))
			rdata_nxt[PFIL_CREDIT_LSB +: 8] = credit_r;
	end

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rdata_r  <= '0;
			rvalid_r <= 1'b0;
		end
		else
		begin
			rvalid_r <= cfg_rd_in;
			if (cfg_rd_in)
				rdata_r <= rdata_nxt;
		end
	end

	assign cfg_rdata_out     = rdata_r;
	assign cfg_rvalid_out    = rvalid_r;
	assign app_iface_off_out = off_r;
	assign xfer_begin_out    = xfer_r;
	assign xfer_config_out   = cfgb_r;
	assign img_data_out      = img_data_r;
	assign img_valid_out     = img_valid_r;
	assign img_space_out     = space_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	sequence s_status_rd;
		cfg_rd_in && pfil_hit(cfg_addr_in, PFIL_STATUS_OFS);
	endsequence

	sequence s_mode_rd;
		cfg_rd_in && pfil_hit(cfg_addr_in, PFIL_MODE_OFS);
	endsequence

	a_status_ok: assert property (@(posedge clock_in) disable iff (rst_in)
		s_status_rd |=> cfg_rdata_out[PFIL_STATUS_SHIFT + PFIL_ST_OK] == $past(sts_r.ok))
		else $error("success flag misreported");
	a_status_done: assert property (@(posedge clock_in) disable iff (rst_in)
		s_status_rd |=> cfg_rdata_out[PFIL_STATUS_SHIFT + PFIL_ST_DONE] == $past(sts_r.done))
		else $error("done flag misreported");
	a_status_user: assert property (@(posedge clock_in) disable iff (rst_in)
		s_status_rd |=> cfg_rdata_out[PFIL_STATUS_SHIFT + PFIL_ST_USER] == $past(sts_r.user))
		else $error("user mode flag misreported");
	a_status_en: assert property (@(posedge clock_in) disable iff (rst_in)
		s_status_rd |=> cfg_rdata_out[PFIL_STATUS_SHIFT + PFIL_ST_EN] == $past(sts_r.en))
		else $error("enable flag misreported");
	a_status_err: assert property (@(posedge clock_in) disable iff (rst_in)
		s_status_rd |=> cfg_rdata_out[PFIL_STATUS_SHIFT + PFIL_ST_ERR] == $past(sts_r.err))
		else $error("error flag misreported");
	a_status_ready: assert property (@(posedge clock_in) disable iff (rst_in)
		s_status_rd |=> cfg_rdata_out[PFIL_STATUS_SHIFT + PFIL_ST_READY] == $past(sts_r.ready))
		else $error("ready flag misreported");
	a_status_clk: assert property (@(posedge clock_in) disable iff (rst_in)
		s_status_rd |=> cfg_rdata_out[PFIL_STATUS_SHIFT + PFIL_ST_CLK] == $past(sts_r.clk_sel))
		else $error("clock select flag misreported");
	a_mode_write: assert property (@(posedge clock_in) disable iff (rst_in)
		cfg_wr_in && pfil_hit(cfg_addr_in, PFIL_MODE_OFS) && cfg_be_in[0] && sts_r.en
		|=> app_iface_off_out == $past(cfg_wdata_in[PFIL_MODE_OFF]))
		else $error("detach bit not written");
	a_mode_locked: assert property (@(posedge clock_in) disable iff (rst_in)
		!sts_r.en |=> $stable(app_iface_off_out))
		else $error("detach bit changed while loader disabled");
	a_mode_rsvd: assert property (@(posedge clock_in) disable iff (rst_in)
		s_mode_rd ##1 cfg_rvalid_out |-> cfg_rdata_out[PFIL_MODE_RSVD] == 1'b0)
		else $error("reserved mode bit nonzero");
	a_data_fwd: assert property (@(posedge clock_in) disable iff (rst_in)
		cfg_data_wr && fifo_in_ready && !fifo_out_valid && !img_valid_r
		|=> ##1 img_valid_out && img_data_out == $past(cfg_wdata_in, 2))
		else $error("data word not forwarded");
	a_bar_gate: assert property (@(posedge clock_in) disable iff (rst_in)
		mem_wr_in && mem_bar_hit_in && !sts_r.en && !cfg_data_wr |-> !fifo_in_valid)
		else $error("BAR write taken outside loader mode");
	a_prog_bits: assert property (@(posedge clock_in) disable iff (rst_in)
		cfg_wr_in && pfil_hit(cfg_addr_in, PFIL_PROG_OFS) && cfg_be_in[0]
		|=> xfer_begin_out == $past(cfg_wdata_in[PFIL_PROG_XFER])
		&& xfer_config_out == $past(cfg_wdata_in[PFIL_PROG_CFG]))
		else $error("programming control not written");
	a_credit_inc: assert property (@(posedge clock_in) disable iff (rst_in)
		credit_free_in |=> credit_r == $past(credit_r) + 8'h01)
		else $error("credit count did not advance");
	a_credit_rsvd: assert property (@(posedge clock_in) disable iff (rst_in)
		cfg_rd_in && pfil_hit(cfg_addr_in, PFIL_CREDIT_OFS)
		|=> cfg_rdata_out[7:0] == 8'h00 && cfg_rdata_out[31:16] == 16'h0000)
		else $error("reserved credit bits nonzero");

endmodule : pfil_regs

// >>> bench/pfil_host_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Host driver model: one configuration or memory request at a time.
module pfil_host_model (
	input  wire logic        clock_in,
	input  wire logic [31:0] rdata_in,
	input  wire logic        rvalid_in,
	output logic             wr_out,
	output logic             rd_out,
	output logic [11:0]      addr_out,
	output logic [3:0]       be_out,
	output logic [31:0]      wdata_out,
	output logic             mem_wr_out,
	output logic             hit_out,
	output logic [31:0]      mem_wdata_out
);
	// Idle bus at time zero.
	initial
	begin
		{wr_out, rd_out, addr_out, be_out, wdata_out} = '0;
		{mem_wr_out, hit_out, mem_wdata_out} = '0;
	end

	// A request is held until the taking edge, then dropped; data lines invert so stale values never match.
	task cfg_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clock_in);
		#1;
		{wr_out, addr_out, wdata_out, be_out} = {1'b1, a, d, be};
		@(posedge clock_in);
		#1;
		wr_out = 1'b0;
		wdata_out = ~d;
	endtask : cfg_write

	// Image words always carry all four byte lanes.
	task data_write(input logic [11:0] a, input logic [31:0] d);
		cfg_write(a, d, 4'hf);
	endtask : data_write

	// Read answer is taken 1 ns after the taking edge.
	task cfg_read(input logic [11:0] a, output logic [31:0] d, output logic v);
		@(posedge clock_in);
		#1;
		{rd_out, addr_out} = {1'b1, a};
		@(posedge clock_in);
		#1;
		rd_out = 1'b0;
		d = rdata_in;
		v = rvalid_in;
	endtask : cfg_read

	// Memory write to a decoded address or, for a miss, to an undecoded one.
	task mem_write(input logic [31:0] d, input logic hit);
		@(posedge clock_in);
		#1;
		{mem_wr_out, hit_out, mem_wdata_out} = {1'b1, hit, d};
		@(posedge clock_in);
		#1;
		{mem_wr_out, hit_out, mem_wdata_out} = {2'b00, ~d};
	endtask : mem_write

	// Link kept silent for 10 us around a change of the detach bit; 2000 cycles at 5 ns.
	task quiet;
		repeat (2000) @(posedge clock_in);
	endtask : quiet

endmodule : pfil_host_model

// >>> bench/pcie_fabric_image_loader_regs_tb_top.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module pcie_fabric_image_loader_regs_tb_top import pfil_pkg::*;;
	logic         clock_in, rst_in, cfg_wr, cfg_rd, rvalid, mem_wr, hit, credit_free;
	logic         iface_off, xbegin, xcfg, img_valid, img_ready, img_space, hold, v;
	logic [11:0]  addr;
	logic [3:0]   be;
	logic [31:0]  wdata, rdata, mem_wdata, img_data, rd_val, d;
	pfil_status_t st;
	logic [31:0]  exp_q[$];
	int           miscompares, checked, i, n;
	localparam logic [11:0] SDW = {PFIL_STATUS_OFS[11:2], 2'b00};

	pfil_host_model host (.clock_in(clock_in), .rdata_in(rdata), .rvalid_in(rvalid), .wr_out(cfg_wr),
		.rd_out(cfg_rd), .addr_out(addr), .be_out(be), .wdata_out(wdata), .mem_wr_out(mem_wr),
		.hit_out(hit), .mem_wdata_out(mem_wdata));

	pfil_regs dut (.clock_in(clock_in), .rst_in(rst_in), .cfg_wr_in(cfg_wr), .cfg_rd_in(cfg_rd),
		.cfg_addr_in(addr), .cfg_be_in(be), .cfg_wdata_in(wdata), .cfg_rdata_out(rdata),
		.cfg_rvalid_out(rvalid), .mem_wr_in(mem_wr), .mem_bar_hit_in(hit), .mem_wdata_in(mem_wdata),
		.status_in(st), .credit_free_in(credit_free), .app_iface_off_out(iface_off),
		.xfer_begin_out(xbegin), .xfer_config_out(xcfg), .img_data_out(img_data),
		.img_valid_out(img_valid), .img_ready_in(img_ready), .img_space_out(img_space));

	// Clock of 5 ns period.
	initial
	begin
		clock_in = 1'b0;
		forever #2.5 clock_in = ~clock_in;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Compare task for every register value, flag and image word.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// A read must be answered and carry the expected value.
	task rd_chk(input logic [11:0] a, input logic [31:0] exp);
		host.cfg_read(a, rd_val, v);
		chk({31'h0, v}, 32'h1);
		chk(rd_val, exp);
	endtask : rd_chk

	// Status half is built from the package field positions.
	function automatic logic [31:0] exp_status(input pfil_status_t s);
		logic [15:0] h;
		h = '0;
		h[PFIL_ST_OK] = s.ok;
		h[PFIL_ST_CLK] = s.clk_sel;
		h[PFIL_ST_DONE] = s.done;
		h[PFIL_ST_USER] = s.user;
		h[PFIL_ST_EN] = s.en;
		h[PFIL_ST_ERR] = s.err;
		h[PFIL_ST_READY] = s.ready;
		return {h, PFIL_BOARD_ID};
	endfunction : exp_status

	// Status inputs pass a two-stage synchroniser, so allow a few edges to settle.
	task set_status(input pfil_status_t s);
		@(posedge clock_in);
		#1;
		st = s;
		repeat (4) @(posedge clock_in);
	endtask : set_status

	// Bounded wait until every expected image word has been consumed.
	task drain;
		for (n = 0; n < 300 && exp_q.size() != 0; n++) @(posedge clock_in);
		chk(exp_q.size(), 32'h0);
	endtask : drain

	task results;
		$display("compares %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////////////////////
	// Manager side: stalls at random, or fully while hold is set.
	always @(posedge clock_in)
	begin
		#1;
		img_ready = !hold && ($urandom % 4 != 0);
	end

	// Every consumed word must be the oldest one still expected.
	always @(posedge clock_in)
		if (!rst_in && img_valid && img_ready)
			chk(img_data, exp_q.size() ? exp_q.pop_front() : ~img_data);

	// Watchdog sized well above the roughly 7000 cycles the tests need.
	initial
	begin
		#200000;
		miscompares++;
		results();
	end

	initial
	begin
		{rst_in, st, credit_free, hold} = {1'b1, 7'h00, 2'b00};
		void'($urandom(32'h7820));
		repeat (8) @(posedge clock_in);
		#1;
		rst_in = 1'b0;
		// Reset values of every register but the data port, an unmapped place and the control outputs.
		rd_chk(SDW, 32'h0);
		rd_chk(PFIL_MODE_OFS, 32'h0);
		rd_chk(PFIL_PROG_OFS, 32'h0);
		rd_chk(PFIL_CREDIT_OFS, 32'h0);
		rd_chk(12'h100, 32'h0);
		chk({28'h0, iface_off, xbegin, xcfg, img_valid}, 32'h0);
		$display("test reset done");
		// Walking one over each status flag, then random mixes.
		for (i = 0; i < 12; i++)
		begin
			set_status(i < 7 ? 7'h01 << i : 7'($urandom));
			rd_chk(SDW, exp_status(st));
		end
		$display("test status done");
		// Detach bit is read-only while the loader is disabled.
		set_status(7'h00);
		host.cfg_write(PFIL_MODE_OFS, 32'h2, 4'hf);
		rd_chk(PFIL_MODE_OFS, 32'h0);
		st.en = 1'b1;
		set_status(st);
		host.quiet();
		host.cfg_write(PFIL_MODE_OFS, 32'h6, 4'h0);
		rd_chk(PFIL_MODE_OFS, 32'h0);
		host.cfg_write(PFIL_MODE_OFS, 32'hffffffff, 4'hf);
		rd_chk(PFIL_MODE_OFS, 32'h2);
		chk({31'h0, iface_off}, 32'h1);
		host.quiet();
		host.cfg_write(PFIL_MODE_OFS, 32'h0, 4'hf);
		chk({31'h0, iface_off}, 32'h0);
		host.quiet();
		$display("test mode done");
		// Every programming code, upper bits random.
		for (i = 0; i < 4; i++)
		begin
			d = $urandom;
			d[1:0] = i[1:0];
			host.cfg_write(PFIL_PROG_OFS, d, 4'hf);
			rd_chk(PFIL_PROG_OFS, {30'h0, i[1:0]});
			chk({30'h0, xbegin, xcfg}, {30'h0, i[1:0]});
		end
		host.cfg_write(PFIL_PROG_OFS, 32'h0, 4'h0);
		chk({30'h0, xbegin, xcfg}, 32'h3);
		$display("test program done");
		// Freed buffers counted around the eight-bit wrap, 253 to 259 of them.
		n = 253 + $urandom_range(0, 6);
		repeat (n)
		begin
			@(posedge clock_in);
			#1 credit_free = 1'b1;
			@(posedge clock_in);
			#1 credit_free = 1'b0;
		end
		rd_chk(PFIL_CREDIT_OFS, {16'h0, n[7:0], 8'h00});
		$display("test credit done");
		// Mixed stream; the host waits for space before each word.
		st.ready = 1'b1;
		set_status(st);
		rd_chk(SDW, exp_status(st));
		for (i = 0; i < 24; i++)
		begin
			// The space hint lags by a cycle, so let the last word show in it first.
			repeat (2) @(posedge clock_in);
			for (n = 0; n < 50 && !img_space; n++) @(posedge clock_in);
			d = $urandom;
			if (i % 4 < 2)
				host.data_write(i % 4 ? PFIL_DATA1_OFS : PFIL_DATA0_OFS, d);
			else
				host.mem_write(d, i % 4 == 2);
			if (i % 4 != 3)
				exp_q.push_back(d);
		end
		drain();
		st.en = 1'b0;
		set_status(st);
		host.mem_write(32'h5a5a0001, 1'b1);
		drain();
		// Overfill with the manager stalled: four slots plus the output stage.
		hold = 1'b1;
		for (i = 0; i < 7; i++)
		begin
			d = $urandom;
			host.data_write(PFIL_DATA0_OFS, d);
			if (i < 5)
				exp_q.push_back(d);
		end
		repeat (2) @(posedge clock_in);
		chk({31'h0, img_space}, 32'h0);
		rd_chk(PFIL_DATA0_OFS, exp_q[4]);
		hold = 1'b0;
		drain();
		chk({31'h0, img_space}, 32'h1);
		$display("test stream done");
		results();
	end

endmodule : pcie_fabric_image_loader_regs_tb_top
